/* logic/twe_slave.sv */
// two-wire eeprom slave: bus protocol, page buffer, array and write timer

module twe_slave #(
    parameter int WR_CYC = twe_pkg::WR_CYC
) (
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic CE_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    input wire logic CHIP_SELECT_BIT2_IN,
    input wire logic CHIP_SELECT_BIT1_IN,
    input wire logic CHIP_SELECT_BIT0_IN,
    input wire logic WRITE_PROTECT_IN,
    output logic STANDBY_OUT,
    output logic BUSY_OUT
);
    import twe_pkg::*;

    // mclk domain
    logic scl_s1_r, scl_s2_r;
    logic sda_s1_r, sda_s2_r, sda_d_r;
    logic wp_s1_r, wp_s2_r;
    logic pend_s1_r, pend_s2_r;
    logic eng_s1_r, eng_s2_r;
    logic start_ev, stop_ev;
    logic hold_r, hold_nxt;
    logic [1:0] pcnt_r, pcnt_nxt;
    logic frm_rst_r, frm_rst_nxt;
    logic in_frame_r, in_frame_nxt;
    logic standby_r, standby_nxt;
    twe_wr_t wst_r, wst_nxt;
    logic [TMR_W-1:0] tmr_r, tmr_nxt;
    logic [ROW_W-1:0] row_r, row_nxt;
    logic [PAGE_W-1:0] slot;
    logic mem_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [7:0] mem_wd;
    logic [7:0] mem [0:MEM_BYTES-1];

    // scl domain
    logic scl_rst_n;
    twe_proto_t pst_r, pst_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [HI_W-1:0] adh_r, adh_nxt;
    logic ack_r, ack_nxt;
    logic pend_r, pend_nxt;
    logic [7:0] rd_r, rd_nxt;
    logic oe_r, oe_nxt;
    logic [7:0] rx_byte;
    logic bit7, bit8;
    logic ev_dev_wr, ev_dev_rd, ev_adl, ev_wdat, ev_rnext;
    logic [ADDR_W-1:0] ptr_r, ptr_nxt;
    logic [PAGE_BYTES-1:0] mask_r, mask_nxt;
    logic [2:0] cs_s1_r, cs_s2_r;
    logic busy_s1_r, busy_s2_r;
    logic [7:0] pbuf [0:PAGE_BYTES-1];

    // ------------------------------------------------------------------
    // mclk side: bus condition watch, frame reset, write cycle
    // ------------------------------------------------------------------

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r <= 1'b1;
            wp_s1_r <= 1'b0;
            wp_s2_r <= 1'b0;
            pend_s1_r <= 1'b0;
            pend_s2_r <= 1'b0;
            eng_s1_r <= 1'b0;
            eng_s2_r <= 1'b0;
        end else if (CE_IN) begin
            scl_s1_r <= SCL_IN;
            scl_s2_r <= scl_s1_r;
            sda_s1_r <= SDA_IN;
            sda_s2_r <= sda_s1_r;
            sda_d_r <= sda_s2_r;
            wp_s1_r <= WRITE_PROTECT_IN;
            wp_s2_r <= wp_s1_r;
            pend_s1_r <= pend_r;
            pend_s2_r <= pend_s1_r;
            eng_s1_r <= (pst_r != P_IGN);
            eng_s2_r <= eng_s1_r;
        end
    end

    // only an sda edge while scl is high counts as a condition
    assign start_ev = scl_s2_r & sda_d_r & ~sda_s2_r;
    assign stop_ev = scl_s2_r & ~sda_d_r & sda_s2_r;

    // scl may stand still between frames, so the link logic cannot see a
    // stop itself; it is held in reset from stop to start, and pulsed
    // on a repeated start while scl is still high
    always_comb begin
        hold_nxt = hold_r;
        pcnt_nxt = pcnt_r;
        in_frame_nxt = in_frame_r;
        if (pcnt_r != 2'h0) begin
            pcnt_nxt = pcnt_r - 2'h1;
        end
        if (start_ev) begin
            hold_nxt = 1'b0;
            pcnt_nxt = FRM_PULSE;
            in_frame_nxt = 1'b1;
        end
        if (stop_ev) begin
            hold_nxt = 1'b1;
            in_frame_nxt = 1'b0;
        end
        frm_rst_nxt = hold_nxt | (pcnt_nxt != 2'h0);
        // read stop or mismatched address: standby at once
        standby_nxt = ~(in_frame_nxt & eng_s2_r) & (wst_nxt == W_IDLE);
    end

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            hold_r <= 1'b1;
            pcnt_r <= 2'h0;
            frm_rst_r <= 1'b1;
            in_frame_r <= 1'b0;
            standby_r <= 1'b1;
        end else if (CE_IN) begin
            hold_r <= hold_nxt;
            pcnt_r <= pcnt_nxt;
            frm_rst_r <= frm_rst_nxt;
            in_frame_r <= in_frame_nxt;
            standby_r <= standby_nxt;
        end
    end

    // page buffer, mask and pointer are read here from the stop on; the link
    // logic refuses every device address while busy, so they stand still
    assign slot = tmr_r[PAGE_W:1];

    always_comb begin
        wst_nxt = wst_r;
        tmr_nxt = tmr_r;
        row_nxt = row_r;
        mem_we = 1'b0;
        mem_wa = {row_r, slot};
        mem_wd = ERASED_BYTE;
        if (wst_r != W_IDLE) begin
            tmr_nxt = tmr_r + TMR_W'(1);
        end
        unique case (wst_r)
            W_IDLE: begin
                if (stop_ev && pend_s2_r && !wp_s2_r) begin
                    wst_nxt = W_ERASE;
                    tmr_nxt = '0;
                    row_nxt = ptr_r[ADDR_W-1:PAGE_W];
                end
            end
            W_ERASE: begin
                mem_we = mask_r[slot];
                wst_nxt = W_PROG;
            end
            W_PROG: begin
                mem_we = mask_r[slot];
                mem_wd = pbuf[slot];
                if (slot == PAGE_W'(PAGE_BYTES - 1)) begin
                    wst_nxt = W_WAIT;
                end else begin
                    wst_nxt = W_ERASE;
                end
            end
            W_WAIT: begin
                if (tmr_r == TMR_W'(WR_CYC - 1)) begin
                    wst_nxt = W_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            wst_r <= W_IDLE;
            tmr_r <= '0;
            row_r <= '0;
        end else if (CE_IN) begin
            wst_r <= wst_nxt;
            tmr_r <= tmr_nxt;
            row_r <= row_nxt;
        end
    end

    // the array itself carries no reset, as a real cell array would not
    always_ff @(posedge MCLK_IN) begin
        if (CE_IN && mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    assign BUSY_OUT = (wst_r != W_IDLE);
    assign STANDBY_OUT = standby_r;

    // ------------------------------------------------------------------
    // scl side: shift, acknowledge, address counter, page buffer
    // ------------------------------------------------------------------

    assign scl_rst_n = RST_N_IN & ~frm_rst_r;

    always_comb begin
        rx_byte = {sh_r[6:0], SDA_IN};
        bit7 = (cnt_r == LAST_DATA_BIT);
        bit8 = (cnt_r == ACK_BIT);
        ev_dev_wr = 1'b0;
        ev_dev_rd = 1'b0;
        ev_adl = 1'b0;
        ev_wdat = 1'b0;
        ev_rnext = 1'b0;
        pst_nxt = pst_r;
        cnt_nxt = bit8 ? 4'h0 : cnt_r + 4'h1;
        sh_nxt = rx_byte;
        adh_nxt = adh_r;
        ack_nxt = bit8 ? 1'b0 : ack_r;
        pend_nxt = pend_r;
        rd_nxt = rd_r;
        unique case (pst_r)
            P_DEV: begin
                if (bit7) begin
                    if (rx_byte[7:4] == CLASS_CODE
                        && rx_byte[3:1] == cs_s2_r
                        && !busy_s2_r) begin
                        ack_nxt = 1'b1;
                        if (rx_byte[0]) begin
                            ev_dev_rd = 1'b1;
                            pst_nxt = P_RDAT;
                        end else begin
                            ev_dev_wr = 1'b1;
                            pst_nxt = P_ADH;
                        end
                    end else begin
                        pst_nxt = P_IGN;
                    end
                end
            end
            P_ADH: begin
                if (bit7) begin
                    ack_nxt = 1'b1;
                    adh_nxt = rx_byte[HI_W-1:0];
                    pst_nxt = P_ADL;
                end
            end
            P_ADL: begin
                if (bit7) begin
                    ack_nxt = 1'b1;
                    ev_adl = 1'b1;
                    pst_nxt = P_WDAT;
                end
            end
            P_WDAT: begin
                if (bit7) begin
                    ack_nxt = 1'b1;
                    ev_wdat = 1'b1;
                    pend_nxt = 1'b1;
                end
            end
            P_RDAT: begin
                // the first ninth clock is our own address acknowledge
                if (bit8 && !ack_r) begin
                    if (!SDA_IN) begin
                        ev_rnext = 1'b1;
                    end else begin
                        pst_nxt = P_IGN;
                    end
                end
            end
            P_IGN: begin
                pst_nxt = P_IGN;
            end
            default: begin
                pst_nxt = P_IGN;
            end
        endcase
        if (ev_dev_rd || ev_rnext) begin
            // array is stable here: no read is accepted while busy
            rd_nxt = mem[ptr_r];
        end
    end

    always_ff @(posedge SCL_IN or negedge scl_rst_n) begin
        if (!scl_rst_n) begin
            pst_r <= P_DEV;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            adh_r <= '0;
            ack_r <= 1'b0;
            pend_r <= 1'b0;
            rd_r <= 8'h00;
        end else begin
            pst_r <= pst_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            adh_r <= adh_nxt;
            ack_r <= ack_nxt;
            pend_r <= pend_nxt;
            rd_r <= rd_nxt;
        end
    end

    // sda is only ever pulled low, and only after a falling scl edge
    always_comb begin
        oe_nxt = 1'b0;
        if (cnt_r == ACK_BIT) begin
            oe_nxt = ack_r;
        end else if (pst_r == P_RDAT) begin
            oe_nxt = ~rd_r[3'(LAST_DATA_BIT - cnt_r)];
        end
    end

    always_ff @(negedge SCL_IN or negedge scl_rst_n) begin
        if (!scl_rst_n) begin
            oe_r <= 1'b0;
        end else begin
            oe_r <= oe_nxt;
        end
    end

    assign SDA_OUT = 1'b0;
    assign SDA_OE_OUT = oe_r;

    // pointer and page mask outlive frames, so they skip the frame reset; the mask clears on the pin reset and on each accepted write address
    always_comb begin
        ptr_nxt = ptr_r;
        mask_nxt = mask_r;
        if (ev_adl) begin
            ptr_nxt = {adh_r, rx_byte};
        end else if (ev_wdat) begin
            // page row stays fixed, offset wraps inside it
            ptr_nxt[PAGE_W-1:0] = ptr_r[PAGE_W-1:0] + PAGE_W'(1);
            mask_nxt[ptr_r[PAGE_W-1:0]] = 1'b1;
        end else if (ev_dev_rd || ev_rnext) begin
            ptr_nxt = ptr_r + ADDR_W'(1);
        end
        if (ev_dev_wr) begin
            mask_nxt = '0;
        end
    end

    always_ff @(posedge SCL_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ptr_r <= '0;
            mask_r <= '0;
            cs_s1_r <= 3'h0;
            cs_s2_r <= 3'h0;
            busy_s1_r <= 1'b0;
            busy_s2_r <= 1'b0;
        end else begin
            ptr_r <= ptr_nxt;
            mask_r <= mask_nxt;
            cs_s1_r <= {CHIP_SELECT_BIT2_IN, CHIP_SELECT_BIT1_IN,
                        CHIP_SELECT_BIT0_IN};
            cs_s2_r <= cs_s1_r;
            // seven address clocks pass before this is used, on the eighth
            busy_s1_r <= BUSY_OUT;
            busy_s2_r <= busy_s1_r;
        end
    end

    always_ff @(posedge SCL_IN) begin
        if (ev_wdat) begin
            pbuf[ptr_r[PAGE_W-1:0]] <= rx_byte;
        end
    end
endmodule

/* logic/twe_pkg.sv */
// constants and types shared by the two-wire eeprom slave
package twe_pkg;
    // array geometry: 256 pages of 32 bytes, 13-bit byte address
    localparam int ADDR_W = 13;
    localparam int PAGE_W = 5;
    localparam int PAGE_BYTES = 32;
    localparam int ROW_W = ADDR_W - PAGE_W;
    localparam int HI_W = ADDR_W - 8;
    localparam int MEM_BYTES = 8192;

    // device address word and byte framing
    localparam logic [3:0] CLASS_CODE = 4'hA;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // mclk cycles that the link logic is held in reset after a start
    localparam logic [1:0] FRM_PULSE = 2'h2;

    // self-timed write cycle, longest time rounded down to cycles
    localparam int MCLK_MHZ = 20;
    localparam int WR_TIME_US = 5000;
    localparam int WR_CYC = WR_TIME_US * MCLK_MHZ;
    localparam int TMR_W = 17;

    typedef enum logic [2:0] {
        P_DEV = 3'h0,
        P_ADH = 3'h1,
        P_ADL = 3'h3,
        P_WDAT = 3'h2,
        P_RDAT = 3'h4,
        P_IGN = 3'h6
    } twe_proto_t;

    typedef enum logic [1:0] {
        W_IDLE = 2'h0,
        W_ERASE = 2'h1,
        W_PROG = 2'h3,
        W_WAIT = 2'h2
    } twe_wr_t;
endpackage

/* verification/twe_slave_chk.sv */
// concurrent checks on the ports of the eeprom slave
module twe_slave_chk #(
    parameter int WR_CYC = 200
) (
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic SDA_OE_OUT,
    input wire logic STANDBY_OUT,
    input wire logic BUSY_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned busy_cnt_r;
    int unsigned busy_cnt_nxt;
    always_comb begin
        busy_cnt_nxt = BUSY_OUT ? busy_cnt_r + 1 : 0;
    end
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= busy_cnt_nxt;
        end
    end
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    // scl already high one sample earlier, so a release at scl rise is no stop
    sequence stop_seen;
        SCL_IN && $past(SCL_IN) && $rose(SDA_IN);
    endsequence
    sequence settles;
        ##[1:8] (BUSY_OUT || STANDBY_OUT);
    endsequence
    AST_RESET_IDLE: assert property (
        $rose(RST_N_IN) |-> STANDBY_OUT && !BUSY_OUT && !SDA_OE_OUT)
        else $error("outputs not idle after reset");
    AST_DRIVE_LOW: assert property (
        $changed(SDA_OE_OUT) |-> !SCL_IN)
        else $error("data line drive moved while scl high");
    AST_BUSY_ENTER: assert property (
        $rose(BUSY_OUT) |=> !STANDBY_OUT)
        else $error("standby while write cycle starts");
    AST_BUSY_EXIT: assert property (
        $fell(BUSY_OUT) |-> ##[0:1] STANDBY_OUT)
        else $error("no standby after write cycle");
    AST_BUSY_MAX: assert property (
        busy_cnt_r <= WR_CYC)
        else $error("write cycle too long");
    AST_BUSY_MIN: assert property (
        $fell(BUSY_OUT) |-> busy_cnt_r >= WR_CYC - 1)
        else $error("write cycle too short");
    AST_NO_DRIVE_BUSY: assert property (
        BUSY_OUT |-> !SDA_OE_OUT)
        else $error("device answered during write cycle");
    AST_ADDR_LEAVES_STBY: assert property (
        $rose(SDA_OE_OUT) |-> ##[0:6] !STANDBY_OUT)
        else $error("device drove the line while in standby");
    AST_STOP_SETTLES: assert property (
        stop_seen ##0 (!BUSY_OUT && !STANDBY_OUT) |-> settles)
        else $error("stop left device neither busy nor in standby");
endmodule

/* verification/twe_master.sv */
// bus master model for the two-wire link
module twe_master (
    output logic scl_out,
    output logic sda_out,
    input wire logic sda_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_out = 1'h1;
        sda_out = 1'h1;
    end
    // low phase stretched to 120 ns so the mclk-side detector never sees
    // scl and sda move in one sample; data moves mid low phase
    task automatic bit_xfer(input logic o, output logic i);
        #60 sda_out = o;
        #60 scl_out = 1'h1;
        i = sda_in;
        #40 scl_out = 1'h0;
    endtask
    // odd offset keeps link edges off the mclk edges
    task automatic start();
        #3;
        if (!scl_out) begin
            #60 sda_out = 1'h1;
            #60 scl_out = 1'h1;
            #160;
        end
        sda_out = 1'h0;
        #400 scl_out = 1'h0;
    endtask
    task automatic stop();
        #60 sda_out = 1'h0;
        #60 scl_out = 1'h1;
        #160 sda_out = 1'h1;
        #200;
    endtask
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int k = 7; k >= 0; k--) begin
            bit_xfer(b[k], s);
        end
        bit_xfer(1'h1, s);
        ack = !s;
    endtask
    task automatic rd_byte(input logic more, output logic [7:0] b);
        logic s;
        for (int k = 7; k >= 0; k--) begin
            bit_xfer(1'h1, b[k]);
        end
        bit_xfer(!more, s);
    endtask
endmodule

/* verification/twe_slave_tb.sv */
// self-checking bench for the two-wire eeprom slave
module twe_slave_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WR_CYC_TB = 200;
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic ce = 1'h1;
    logic wp = 1'h0;
    logic [2:0] cs = 3'h5;
    logic scl, sda_m, sda_o, sda_oe, sda_w, standby, busy;
    int n_fail = 0;
    int checks = 0;
    assign sda_w = sda_m & (sda_oe ? sda_o : 1'h1);
    twe_master m (.scl_out(scl), .sda_out(sda_m), .sda_in(sda_w));
    twe_slave #(.WR_CYC(WR_CYC_TB)) dut (
        .MCLK_IN(mclk), .RST_N_IN(rst_n), .CE_IN(ce), .SCL_IN(scl),
        .SDA_IN(sda_w), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe),
        .CHIP_SELECT_BIT2_IN(cs[2]), .CHIP_SELECT_BIT1_IN(cs[1]),
        .CHIP_SELECT_BIT0_IN(cs[0]), .WRITE_PROTECT_IN(wp),
        .STANDBY_OUT(standby), .BUSY_OUT(busy));
    initial begin
        forever #25 mclk = ~mclk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic a;
        m.wr_byte(b, a);
        check({7'h0, a}, {7'h0, exp_ack}, "acknowledge");
    endtask
    task automatic recv(input logic more, input logic [7:0] exp);
        logic [7:0] d;
        m.rd_byte(more, d);
        check(d, exp, "read byte");
    endtask
    task automatic begin_frame();
        @(negedge mclk);
        m.start();
    endtask
    // stop, then give the mclk-side detector time to react
    task automatic end_frame();
        m.stop();
        repeat (8) @(negedge mclk);
    endtask
    task automatic wait_idle();
        int n;
        for (n = 0; n < WR_CYC_TB + 50; n++) begin
            @(negedge mclk);
            if (busy === 1'h0 && standby === 1'h1) break;
        end
        if (n >= WR_CYC_TB + 50) begin
            check(8'h01, 8'h00, "write cycle end");
            test_done();
        end
    endtask
    initial begin
        logic [7:0] e;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'h1;
        repeat (3) @(negedge mclk);
        check({6'h0, standby, busy}, 8'h02, "idle outputs");
        begin_frame();
        send(8'h2A, 1'h0);
        end_frame();
        begin_frame();
        send(8'hA8, 1'h0);
        // still inside the frame: a wrong chip select drops to standby at once
        repeat (4) @(negedge mclk);
        check({7'h0, standby}, 8'h01, "standby in refused frame");
        end_frame();
        check({7'h0, standby}, 8'h01, "standby after refusal");
        begin_frame();
        send(8'hAA, 1'h1);
        send(8'h00, 1'h1);
        send(8'h00, 1'h1);
        send(8'h5A, 1'h1);
        end_frame();
        check({6'h0, standby, busy}, 8'h01, "write cycle running");
        begin_frame();
        send(8'hAB, 1'h0);
        end_frame();
        wait_idle();
        begin_frame();
        send(8'hAA, 1'h1);
        send(8'h00, 1'h1);
        send(8'h00, 1'h1);
        m.start();
        send(8'hAB, 1'h1);
        recv(1'h0, 8'h5A);
        end_frame();
        @(negedge mclk);
        wp = 1'h1;
        begin_frame();
        send(8'hAA, 1'h1);
        send(8'h00, 1'h1);
        send(8'h00, 1'h1);
        send(8'hC3, 1'h1);
        end_frame();
        wait_idle();
        wp = 1'h0;
        // start two bytes before the page end so the offset wraps twice
        begin_frame();
        send(8'hAA, 1'h1);
        send(8'hFF, 1'h1);
        send(8'hFE, 1'h1);
        for (int i = 0; i < 34; i++) begin
            send(8'h10 + 8'(i), 1'h1);
        end
        end_frame();
        wait_idle();
        begin_frame();
        send(8'hAA, 1'h1);
        send(8'h1F, 1'h1);
        send(8'hE0, 1'h1);
        m.start();
        send(8'hAB, 1'h1);
        recv(1'h1, 8'h12);
        recv(1'h0, 8'h13);
        end_frame();
        check({7'h0, standby}, 8'h01, "standby after read");
        begin_frame();
        send(8'hAB, 1'h1);
        for (int k = 2; k <= 32; k++) begin
            e = (k == 32) ? 8'h5A : 8'h12 + 8'(k);
            recv(k < 32, e);
        end
        end_frame();
        test_done();
    end
endmodule
bind twe_slave twe_slave_chk #(.WR_CYC(WR_CYC)) u_chk (
    .MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .SCL_IN(SCL_IN),
    .SDA_IN(SDA_IN), .SDA_OE_OUT(SDA_OE_OUT), .STANDBY_OUT(STANDBY_OUT),
    .BUSY_OUT(BUSY_OUT));
